/* File: hw/spp_defines.svh */
/*
  Register offsets, field positions and reset values of the serial port pin control block.
  Assumes inclusion by bare name from every file that needs a constant.
*/
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

// register offsets on the plain register port
`define SPP_OFS_DATA    4'h0
`define SPP_OFS_ASSIGN  4'h1
`define SPP_OFS_DIR     4'h2
`define SPP_OFS_CONFIG  4'h3
`define SPP_OFS_STATUS  4'h4

// reset values
`define SPP_RST_DATA    8'h00
`define SPP_RST_ASSIGN  8'h00
`define SPP_RST_DIR     8'h00
`define SPP_RST_CONFIG  8'h00
`define SPP_RST_SYNC    9'h100

// config register fields
`define SPP_CFG_SYNC_EN  0
`define SPP_CFG_MASTER   1
`define SPP_CFG_SYNC_WOR 2
`define SPP_CFG_TX_EN    3
`define SPP_CFG_TX_WOR   4
`define SPP_CFG_MASK     8'h1F

// status register fields
`define SPP_STS_MODE_FAULT_FLAG     0

// pin positions
`define SPP_PIN_MISO 0
`define SPP_PIN_MOSI 1
`define SPP_PIN_SCK  2
`define SPP_PIN_CS0  3
`define SPP_PIN_TX   7

// pin inputs plus the receive pin
`define SPP_SYNC_W 9

`endif

/* File: hw/spp_pad.sv */
/*
  Pad driver stage: turns wanted level and drive into pin out and enable.
  Assumes the external pad resolves the level from the enable.
*/
`timescale 1ns/100ps
module spp_pad (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // wanted levels
  spp_pad_if.pad    pif,
  // pin side
  output      logic [7:0] pin_out,
  output      logic [7:0] pin_oe
);
  logic [7:0] out_d;
  logic [7:0] oe_d;
  logic [7:0] out_q;
  logic [7:0] oe_q;

  // open drain only pulls low, push-pull drives both levels
  assign out_d = pif.want_val & ~pif.open_drn;
  assign oe_d  = pif.want_drv & (~pif.open_drn | ~pif.want_val);

  // registered so the pins never see decode glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 8'h00;
      oe_q  <= 8'h00;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe  = oe_q;
endmodule

/* File: hw/spp_pad_if.sv */
/*
  Carrier between the pin control logic and the pad driver stage.
  Assumes one producer of the wanted levels and one pad stage.
*/
`timescale 1ns/100ps
interface spp_pad_if;
  spp_pkg::spp_byte_t want_val;
  spp_pkg::spp_byte_t want_drv;
  spp_pkg::spp_byte_t open_drn;
  modport ctrl (output want_val, output want_drv, output open_drn);
  modport pad  (input  want_val, input  want_drv, input  open_drn);
endinterface

/* File: hw/spp_pkg.sv */
/*
  Types shared by the serial port pin control modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spp_pkg;
  typedef logic [7:0] spp_byte_t;
  // role of the synchronous serial unit
  typedef enum logic {
    SPP_SLAVE  = 1'b0,
    SPP_MASTER = 1'b1
  } spp_role_t;
endpackage

/* File: hw/spp_sync.sv */
/*
  Three-stage input synchroniser with an agreement filter, one lane per bit.
  Assumes asynchronous inputs; output changes only when stages two and three agree.
*/
`timescale 1ns/100ps
`include "spp_defines.svh"
module spp_sync (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // raw and filtered levels
  input  wire logic [`SPP_SYNC_W-1:0] raw_in,
  output      logic [`SPP_SYNC_W-1:0] clean_out
);
  // per-lane reset level, kept constant so the reset branch loads constants only
  localparam logic [`SPP_SYNC_W-1:0] rst_v = `SPP_RST_SYNC;

  genvar gi;
  generate
    for (gi = 0; gi < `SPP_SYNC_W; gi++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      // first stage feeds only the second
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q  <= rst_v[gi];
          s2_q  <= rst_v[gi];
          s3_q  <= rst_v[gi];
          out_q <= rst_v[gi];
        end else begin
          s1_q <= raw_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign clean_out[gi] = out_q;
    end
  endgenerate
endmodule

/* File: hw/spp_top.sv */
/*
  Port pin control for an eight-pin port shared by a synchronous serial unit,
  the asynchronous transmitter and general-purpose I/O.
  Assumes the serial units sit beside it on SYS_CLK and that the pads
  resolve each pin from PIN_OUT and PIN_OE.
*/
// What this block does
// - writing the data latch stores the byte and drives it on output pins
// - reading the data latch returns the present pin levels
// - assignment bit 0 gives pins 0, 1 and 3-6 to I/O, 1 to the serial unit
// - pin assignment never affects the asynchronous transmitter or receiver
// - pins map to MISO, MOSI, SCK, select 0, selects 1-3; pin 7 transmit
// - pin 2 is I/O unless the synchronous unit is enabled, then SCK
// - pin 7 is I/O unless the transmitter is enabled, then transmit output
// - direction bit 0 makes an input, 1 an output, for I/O pins
// - MISO: master 0 input, 1 off; slave 0 off, 1 drives output
// - MOSI: master 0 off, 1 drives; slave 0 input, 1 off
// - SCK: master 1 drives clock, 0 off; slave 0 clock input, 1 off
// - select 0 faults or drives in master, selects in slave; 1-3 master only
// - the receive pin is always a serial input with no direction bit
// - transmit pin direction applies only while the transmitter is off
// - synchronous wired-or makes output pins 0-6 open drain
// - master select 1 gives master role, 0 slave role
// - synchronous enable 1 hands assigned pins to the unit, 0 keeps I/O
// - a low select 0, assigned and an input, in enabled master role sets the mode fault flag
// - transmitter enable dedicates the transmit pin to the transmitter
// - asynchronous wired-or makes the transmit pin open drain
`timescale 1ns/100ps
`include "spp_defines.svh"
module spp_top (
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  // register port
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output      logic [7:0] REG_RDATA,
  // port pins
  input  wire logic [7:0] PIN_IN,
  output      logic [7:0] PIN_OUT,
  output      logic [7:0] PIN_OE,
  // receive pin and its level toward the asynchronous unit
  input  wire logic       RX_PIN,
  output      logic       RX_DATA,
  // synchronous serial unit, outgoing levels
  input  wire logic       SYNC_MISO_OUT,
  input  wire logic       SYNC_MOSI_OUT,
  input  wire logic       SYNC_SCK_OUT,
  input  wire logic [3:0] SYNC_CS_OUT,
  // synchronous serial unit, incoming levels
  output      logic       SYNC_MISO_IN,
  output      logic       SYNC_MOSI_IN,
  output      logic       SYNC_SCK_IN,
  output      logic       SYNC_SS_N_IN,
  // asynchronous transmitter output level
  input  wire logic       TX_OUT,
  // configuration seen by the serial units
  output      logic       SYNC_ENABLE,
  output      logic       MASTER_SELECT,
  output      logic       TX_ENABLE,
  output      logic       MODE_FAULT
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  spp_pkg::spp_byte_t data_q;
  spp_pkg::spp_byte_t assign_q;
  spp_pkg::spp_byte_t dir_q;
  spp_pkg::spp_byte_t config_q;
  logic               mode_fault_flag_q;
  logic               mode_fault_flag_d;
  spp_pkg::spp_byte_t rdata_q;
  spp_pkg::spp_byte_t rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic wr_data;
  logic wr_assign;
  logic wr_dir;
  logic wr_config;
  logic wr_status;

  assign wr_data   = REG_WR && (REG_ADDR == `SPP_OFS_DATA);
  assign wr_assign = REG_WR && (REG_ADDR == `SPP_OFS_ASSIGN);
  assign wr_dir    = REG_WR && (REG_ADDR == `SPP_OFS_DIR);
  assign wr_config = REG_WR && (REG_ADDR == `SPP_OFS_CONFIG);
  assign wr_status = REG_WR && (REG_ADDR == `SPP_OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields

  logic               sync_en;
  spp_pkg::spp_role_t role;
  logic               sync_wor;
  logic               tx_en;
  logic               tx_wor;
  logic               master;

  // enable and role come from software; the serial units only read them
  assign sync_en  = config_q[`SPP_CFG_SYNC_EN];
  assign role     = spp_pkg::spp_role_t'(config_q[`SPP_CFG_MASTER]);
  assign sync_wor = config_q[`SPP_CFG_SYNC_WOR];
  assign tx_en    = config_q[`SPP_CFG_TX_EN];
  assign tx_wor   = config_q[`SPP_CFG_TX_WOR];
  assign master   = (role == spp_pkg::SPP_MASTER);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [`SPP_SYNC_W-1:0] clean;
  spp_pkg::spp_byte_t     pin_lvl;

  // every pin and the receive pin pass the filter before use
  spp_sync u_sync (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .raw_in    ({RX_PIN, PIN_IN}),
    .clean_out (clean)
  );

  assign pin_lvl = clean[7:0];
  assign RX_DATA = clean[8];

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership

  spp_pkg::spp_byte_t own;
  logic               tx_own;

  // pins 0, 1 and 3..6 follow the assignment bit only while the unit is enabled
  assign own[0] = sync_en & assign_q[0];
  assign own[1] = sync_en & assign_q[1];
  // pin 2 becomes the clock whenever the unit is enabled
  // limitation: assignment bit 2 is ignored, the clock pin follows the enable alone
  assign own[2] = sync_en;
  assign own[3] = sync_en & assign_q[3];
  assign own[4] = sync_en & assign_q[4];
  assign own[5] = sync_en & assign_q[5];
  assign own[6] = sync_en & assign_q[6];
  // pin 7 ignores the assignment register entirely
  assign tx_own = tx_en;
  assign own[7] = tx_own;

  ////////////////////////////////////////////////////////////////////////////
  // serial function drive and level per pin

  spp_pkg::spp_byte_t fn_val;
  spp_pkg::spp_byte_t fn_drv;

  // serial sources in pin order
  assign fn_val = {TX_OUT, SYNC_CS_OUT, SYNC_SCK_OUT, SYNC_MOSI_OUT, SYNC_MISO_OUT};

  // MISO drives only as slave with direction 1
  assign fn_drv[`SPP_PIN_MISO] = ~master & dir_q[`SPP_PIN_MISO];
  // MOSI drives only as master with direction 1
  assign fn_drv[`SPP_PIN_MOSI] = master & dir_q[`SPP_PIN_MOSI];
  // SCK drives only as master with direction 1
  assign fn_drv[`SPP_PIN_SCK]  = master & dir_q[`SPP_PIN_SCK];
  // all chip selects drive only as master; in slave role they stay quiet
  assign fn_drv[6:3]           = {4{master}} & dir_q[6:3];
  // transmitter owns the pin as an output regardless of direction
  assign fn_drv[`SPP_PIN_TX]   = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // serial inputs toward the synchronous unit

  logic miso_take;
  logic mosi_take;
  logic sck_take;
  logic ss_take;

  // an input is taken only where the role and direction select it
  assign miso_take = own[`SPP_PIN_MISO] & master & ~dir_q[`SPP_PIN_MISO];
  assign mosi_take = own[`SPP_PIN_MOSI] & ~master & ~dir_q[`SPP_PIN_MOSI];
  assign sck_take  = own[`SPP_PIN_SCK] & ~master & ~dir_q[`SPP_PIN_SCK];
  assign ss_take   = own[`SPP_PIN_CS0] & ~master & ~dir_q[`SPP_PIN_CS0];

  // disabled inputs rest at neutral levels: data low, select high
  assign SYNC_MISO_IN = miso_take & pin_lvl[`SPP_PIN_MISO];
  assign SYNC_MOSI_IN = mosi_take & pin_lvl[`SPP_PIN_MOSI];
  assign SYNC_SCK_IN  = sck_take & pin_lvl[`SPP_PIN_SCK];
  assign SYNC_SS_N_IN = ~ss_take | pin_lvl[`SPP_PIN_CS0];

  ////////////////////////////////////////////////////////////////////////////
  // mode fault detection

  logic fault_watch;
  logic fault_hit;

  // select 0 as an input in enabled master role watches for another master
  assign fault_watch = own[`SPP_PIN_CS0] & master & ~dir_q[`SPP_PIN_CS0];
  assign fault_hit   = fault_watch & ~pin_lvl[`SPP_PIN_CS0];

  // the flag re-sets every cycle the low select persists, so a clear sticks only after it ends
  // write 1 clears; a fault in the same cycle wins over the clear
  assign mode_fault_flag_d = fault_hit | (mode_fault_flag_q & ~(wr_status & REG_WDATA[`SPP_STS_MODE_FAULT_FLAG]));

  ////////////////////////////////////////////////////////////////////////////
  // final wanted level and drive per pin

  spp_pad_if          pif ();
  spp_pkg::spp_byte_t want_val;
  spp_pkg::spp_byte_t want_drv;
  spp_pkg::spp_byte_t open_drn;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // owned pins take the serial level, others the latch
      assign want_val[gi] = own[gi] ? fn_val[gi] : data_q[gi];
      // direction governs I/O pins and every serial function except the transmitter
      assign want_drv[gi] = own[gi] ? fn_drv[gi] : dir_q[gi];
    end
  endgenerate

  // the transmit pin has its own wired-or choice
  assign open_drn = {tx_wor, {7{sync_wor}}};

  assign pif.want_val = want_val;
  assign pif.want_drv = want_drv;
  assign pif.open_drn = open_drn;

  spp_pad u_pad (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .pif     (pif.pad),
    .pin_out (PIN_OUT),
    .pin_oe  (PIN_OE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path

  spp_pkg::spp_byte_t rd_mux;

  // a pin change reaches a read four edges late: latency traded for metastability safety
  // the data offset reads the pins, not the latch
  assign rd_mux = (REG_ADDR == `SPP_OFS_DATA)   ? pin_lvl :
                  (REG_ADDR == `SPP_OFS_ASSIGN) ? assign_q :
                  (REG_ADDR == `SPP_OFS_DIR)    ? dir_q :
                  (REG_ADDR == `SPP_OFS_CONFIG) ? config_q :
                  (REG_ADDR == `SPP_OFS_STATUS) ? {7'h00, mode_fault_flag_q} :
                  8'h00;

  // read data stand only in the cycle after the strobe
  assign rdata_d = REG_RD ? rd_mux : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  // software registers; reset leaves every pin a plain input
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_q   <= `SPP_RST_DATA;
      assign_q <= `SPP_RST_ASSIGN;
      dir_q    <= `SPP_RST_DIR;
      config_q <= `SPP_RST_CONFIG;
    end else begin
      if (wr_data) begin
        data_q <= REG_WDATA;
      end
      if (wr_assign) begin
        assign_q <= REG_WDATA;
      end
      if (wr_dir) begin
        dir_q <= REG_WDATA;
      end
      if (wr_config) begin
        config_q <= REG_WDATA & `SPP_CFG_MASK;
      end
    end
  end

  // status flag and read data
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_fault_flag_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      mode_fault_flag_q  <= mode_fault_flag_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // the serial units see the configuration straight from the register, no extra stage
  assign REG_RDATA     = rdata_q;
  assign SYNC_ENABLE   = sync_en;
  assign MASTER_SELECT = master;
  assign TX_ENABLE     = tx_en;
  assign MODE_FAULT    = mode_fault_flag_q;

endmodule

/* File: verif/spp_pin_partner.sv */
/*
  Far side of the port: outside devices and a pull-up on every pin.
  Assumes the pads resolve each pin from the block's level and enable.
*/
`timescale 1ns/100ps
module spp_pin_partner (
  // block side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // outside devices
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  output      logic [7:0] pin_in
);
  // a released line floats to the pull-up, so open drain reads high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val) | (~pin_oe & ~ext_drv);
endmodule

/* File: verif/spp_top_properties.sv */
/*
  Checker for the pin control top, watching its ports only.
  Assumes the offsets of spp_defines.svh and a pad stage one edge behind the registers.
*/
`timescale 1ns/100ps
`include "spp_defines.svh"
module spp_top_properties (
  // clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  // pins
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE,
  input wire logic       RX_PIN,
  input wire logic       RX_DATA,
  // serial units
  input wire logic       SYNC_MISO_OUT,
  input wire logic       SYNC_MOSI_OUT,
  input wire logic       TX_OUT,
  input wire logic       SYNC_MISO_IN,
  input wire logic       SYNC_MOSI_IN,
  input wire logic       SYNC_SCK_IN,
  input wire logic       SYNC_SS_N_IN,
  input wire logic       SYNC_ENABLE,
  input wire logic       MASTER_SELECT,
  input wire logic       TX_ENABLE,
  input wire logic       MODE_FAULT
);
  logic [7:0] dat_q, asg_q, dir_q, cfg_q;
  // write decodes for the shadow registers
  wire        wr_dat   = REG_WR && REG_ADDR == `SPP_OFS_DATA;
  wire        wr_asg   = REG_WR && REG_ADDR == `SPP_OFS_ASSIGN;
  wire        wr_dir   = REG_WR && REG_ADDR == `SPP_OFS_DIR;
  wire        wr_cfg   = REG_WR && REG_ADDR == `SPP_OFS_CONFIG;
  wire        clr_w    = REG_WR && REG_ADDR == `SPP_OFS_STATUS && REG_WDATA[`SPP_STS_MODE_FAULT_FLAG];
  wire [2:0]  sync_cfg = cfg_q[2:0];

  // shadows update on the same edge as the design's registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      {dat_q, asg_q, dir_q, cfg_q} <= 32'h0;
    end else begin
      if (wr_dat) dat_q <= REG_WDATA;
      if (wr_asg) asg_q <= REG_WDATA;
      if (wr_dir) dir_q <= REG_WDATA;
      if (wr_cfg) cfg_q <= REG_WDATA & `SPP_CFG_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // the filter needs a settled input before the level may be trusted
  sequence rx_steady;
    $stable(RX_PIN) [*6];
  endsequence
  sequence tx_wants_low;
    $past(TX_ENABLE) && !$past(TX_OUT);
  endsequence

  AST_RDATA_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside the answer cycle");
  AST_GPIO_DRIVE: assert property ($past(cfg_q) == 8'h00 |-> PIN_OE == $past(dir_q) &&
    (PIN_OUT & PIN_OE) == ($past(dat_q) & $past(dir_q))) else $error("io pin drive wrong");
  AST_SYNC_OPEN_DRAIN: assert property ($past(cfg_q) == 8'h04 |-> (PIN_OE & PIN_OUT & 8'h7F) == 8'h00 &&
    (PIN_OE & 8'h7F) == ($past(dir_q) & ~$past(dat_q) & 8'h7F)) else $error("open drain wrong");
  AST_MOSI_MASTER: assert property ($past(sync_cfg) == 3'h3 && $past(asg_q[1]) && $past(dir_q[1])
    |-> PIN_OE[1] && PIN_OUT[1] == $past(SYNC_MOSI_OUT)) else $error("mosi not driven");
  AST_MISO_SLAVE: assert property ($past(sync_cfg) == 3'h1 && $past(asg_q[0]) && $past(dir_q[0])
    |-> PIN_OE[0] && PIN_OUT[0] == $past(SYNC_MISO_OUT)) else $error("miso not driven");
  AST_TX_DRIVE_LOW: assert property (tx_wants_low |-> PIN_OE[7] && !PIN_OUT[7])
    else $error("transmit low not driven");
  AST_RX_FOLLOW: assert property (rx_steady |-> RX_DATA == RX_PIN)
    else $error("receive level lost");
  AST_UNIT_IDLE: assert property (!SYNC_ENABLE |-> SYNC_SS_N_IN && !SYNC_SCK_IN &&
    !SYNC_MISO_IN && !SYNC_MOSI_IN) else $error("unit sees pins while off");
  AST_FAULT_CAUSE: assert property ($rose(MODE_FAULT) |-> $past(MASTER_SELECT) && $past(SYNC_ENABLE))
    else $error("fault outside master role");
  AST_FAULT_HOLD: assert property (MODE_FAULT && !clr_w |=> MODE_FAULT)
    else $error("fault flag dropped");
endmodule

bind spp_top spp_top_properties u_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE), .RX_PIN(RX_PIN), .RX_DATA(RX_DATA), .SYNC_MISO_OUT(SYNC_MISO_OUT),
  .SYNC_MOSI_OUT(SYNC_MOSI_OUT), .TX_OUT(TX_OUT), .SYNC_MISO_IN(SYNC_MISO_IN), .SYNC_MOSI_IN(SYNC_MOSI_IN),
  .SYNC_SCK_IN(SYNC_SCK_IN), .SYNC_SS_N_IN(SYNC_SS_N_IN), .SYNC_ENABLE(SYNC_ENABLE),
  .MASTER_SELECT(MASTER_SELECT), .TX_ENABLE(TX_ENABLE), .MODE_FAULT(MODE_FAULT));

/* File: verif/spp_top_test.sv */
/*
  Self-checking bench for the pin control top, one task per scenario.
  Assumes spp_pin_partner on the pins and the checker bound to the top.
*/
`timescale 1ns/100ps
`include "spp_defines.svh"
module spp_top_test;
  logic       clk, rst_n, reg_wr, reg_rd, rx_pin, miso_o, mosi_o, sck_o, tx_o;
  logic       rx_data, miso_i, mosi_i, sck_i, ss_n_i, sync_en, master_select, tx_en, mode_fault_flag;
  logic [3:0] reg_addr, cs_o;
  logic [7:0] reg_wdata, rdata, pin_in, pin_out, pin_oe, ext_val, ext_drv, rd_v;
  int         n_fail, num_checks;

  spp_top dut (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .RX_PIN(rx_pin),
    .RX_DATA(rx_data), .SYNC_MISO_OUT(miso_o), .SYNC_MOSI_OUT(mosi_o), .SYNC_SCK_OUT(sck_o), .SYNC_CS_OUT(cs_o),
    .SYNC_MISO_IN(miso_i), .SYNC_MOSI_IN(mosi_i), .SYNC_SCK_IN(sck_i), .SYNC_SS_N_IN(ss_n_i), .TX_OUT(tx_o),
    .SYNC_ENABLE(sync_en), .MASTER_SELECT(master_select), .TX_ENABLE(tx_en), .MODE_FAULT(mode_fault_flag));
  spp_pin_partner u_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_drv(ext_drv),
    .pin_in(pin_in));

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    chk8({7'h00, got}, {7'h00, exp}, m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobes drop after their one taken edge; tasks start just after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = rdata;
    chk8(rd_v, exp, m);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(`SPP_OFS_ASSIGN, 8'h00, "assign reset");
    rdc(`SPP_OFS_DIR, 8'h00, "dir reset");
    wr(`SPP_OFS_CONFIG, 8'hE0);
    rdc(`SPP_OFS_CONFIG, 8'h00, "config spare bits");
    rdc(4'h5, 8'h00, "unmapped read");
    chk8(pin_oe, 8'h00, "oe after reset");
    chk1(rx_data, 1'b1, "rx after reset");
    tick(6);
    rdc(`SPP_OFS_DATA, 8'hFF, "pulled-up pins");
  endtask
  task automatic t_gpio();
    wr(`SPP_OFS_DATA, 8'hA5);
    wr(`SPP_OFS_DIR, 8'hFF);
    tick(1);
    chk8(pin_oe, 8'hFF, "all outputs");
    chk8(pin_out, 8'hA5, "latch on pins");
    wr(`SPP_OFS_DIR, 8'h0F);
    ext_drv <= 8'hF0;
    ext_val <= 8'h30;
    tick(6);
    rdc(`SPP_OFS_DATA, 8'h35, "pin levels read");
  endtask
  task automatic t_master();
    wr(`SPP_OFS_ASSIGN, 8'h7F);
    wr(`SPP_OFS_DIR, 8'h1E);
    {mosi_o, sck_o, cs_o} <= 6'h22;
    ext_drv <= 8'h01;
    ext_val <= 8'h01;
    wr(`SPP_OFS_CONFIG, 8'h03);
    tick(6);
    chk8(pin_oe, 8'h1E, "master enables");
    chk8(pin_out & 8'h1E, 8'h12, "master levels");
    chk1(miso_i, 1'b1, "master miso in");
    chk1(mode_fault_flag, 1'b0, "no fault when select out");
    chk1(master_select, 1'b1, "master role out");
    chk1(sync_en, 1'b1, "unit enabled out");
  endtask
  task automatic t_slave();
    wr(`SPP_OFS_CONFIG, 8'h01);
    wr(`SPP_OFS_DIR, 8'h01);
    miso_o <= 1'b1;
    ext_drv <= 8'h0E;
    ext_val <= 8'h06;
    tick(6);
    chk8(pin_oe, 8'h01, "slave enables");
    chk1(pin_out[0], 1'b1, "slave miso out");
    chk1(mosi_i, 1'b1, "slave mosi in");
    chk1(sck_i, 1'b1, "slave clock in");
    chk1(ss_n_i, 1'b0, "slave select in");
    chk1(mode_fault_flag, 1'b0, "no fault as slave");
    chk1(master_select, 1'b0, "slave role out");
  endtask
  task automatic t_fault();
    wr(`SPP_OFS_CONFIG, 8'h03);
    wr(`SPP_OFS_DIR, 8'h00);
    ext_drv <= 8'h08;
    ext_val <= 8'h00;
    tick(6);
    chk1(mode_fault_flag, 1'b1, "fault raised");
    rdc(`SPP_OFS_STATUS, 8'h01, "fault status");
    ext_drv <= 8'h00;
    tick(6);
    chk1(mode_fault_flag, 1'b1, "fault sticky");
    wr(`SPP_OFS_STATUS, 8'h01);
    tick(1);
    chk1(mode_fault_flag, 1'b0, "fault cleared");
  endtask
  task automatic t_tx();
    wr(`SPP_OFS_CONFIG, 8'h08);
    wr(`SPP_OFS_ASSIGN, 8'hFF);
    tick(1);
    chk1(pin_oe[7], 1'b1, "tx pin output");
    chk1(pin_out[7], 1'b0, "tx low");
    chk1(tx_en, 1'b1, "transmitter enabled out");
    tx_o <= 1'b1;
    rx_pin <= 1'b0;
    tick(6);
    chk1(pin_out[7], 1'b1, "tx high");
    chk1(rx_data, 1'b0, "rx follows pin");
    rx_pin <= 1'b1;
    wr(`SPP_OFS_CONFIG, 8'h18);
    tick(6);
    chk1(pin_oe[7], 1'b0, "tx open drain high");
    chk1(rx_data, 1'b1, "rx back high");
    tx_o <= 1'b0;
    tick(2);
    chk1(pin_oe[7], 1'b1, "tx open drain low");
  endtask
  task automatic t_wor();
    wr(`SPP_OFS_CONFIG, 8'h04);
    wr(`SPP_OFS_ASSIGN, 8'h00);
    wr(`SPP_OFS_DATA, 8'h0F);
    wr(`SPP_OFS_DIR, 8'hFF);
    tick(1);
    chk8(pin_oe, 8'hF0, "open drain enables");
    chk8(pin_out & pin_oe, 8'h00, "open drain pulls low");
    rst_n <= 1'b0;
    tick(1);
    chk8(pin_oe, 8'h00, "oe in reset");
    rst_n <= 1'b1;
    tick(1);
    // pins made outputs with no new data show what reset left in the latch
    wr(`SPP_OFS_DIR, 8'hFF);
    tick(1);
    chk8(pin_out, 8'h00, "latch cleared");
    tick(6);
    rdc(`SPP_OFS_DATA, 8'h00, "cleared latch on pins");
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    close_out();
  end

  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, miso_o, mosi_o, sck_o, tx_o} = 7'h00;
    {reg_addr, cs_o, reg_wdata, ext_val, ext_drv} = 32'h0;
    rx_pin = 1'b1;
    n_fail = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_gpio();
    t_master();
    t_slave();
    t_fault();
    t_tx();
    t_wor();
    close_out();
  end
endmodule
